/* design/stlc_defs.svh */
// register offsets, field positions, reset values and vector addresses of the interrupt controller
`ifndef STLC_DEFS_SVH
`define STLC_DEFS_SVH
`define STLC_OFF_ENABLE 4'h0
`define STLC_OFF_LEVEL 4'h4
`define STLC_OFF_STATUS 4'h8
`define STLC_BIT_GLOBAL 7
`define STLC_BIT_UNUSED 6
`define STLC_RST_ENABLE 8'h00
`define STLC_RST_LEVEL 8'h00
`define STLC_LEVEL_MASK 8'h3f
`define STLC_ENABLE_MASK 8'hbf
`define STLC_VEC_EXT_A 16'h0003
`define STLC_VEC_TIMER_A 16'h000b
`define STLC_VEC_EXT_B 16'h0013
`define STLC_VEC_TIMER_B 16'h001b
`define STLC_VEC_ASYNC 16'h0023
`define STLC_VEC_TWOWIRE 16'h002b
`endif

/* design/stlc_irq_ctrl.sv */
// six-source two-level interrupt controller with avalon-mm register port
// Notes on behaviour
// - global enable bit 7 blocks all acceptance
// - enable bit 5 gates two-wire port
// - enable bit 4 gates async port
// - enable bit 3 gates timer b overflow
// - enable bit 2 gates external line b
// - enable bit 1 gates timer a overflow
// - enable bit 0 gates external line a
// - gate 0 blocks, 1 passes; bit 6 unused
// - level bit 5 sets two-wire port level
// - level bit 4 sets async port level
// - level bit 3 sets timer b level
// - level bit 2 sets external line b level
// - level bit 1 sets timer a level
// - level bit 0 sets external a; 7,6 unused
// - vectors 0003, 000b, 0013 for a, timer a, b
// - vectors 001b, 0023, 002b for timer b, async, two-wire
// - two levels with nesting
// - higher level wins among simultaneous requests
// - equal level order: ext a, twowire, ta, ext b, tb, async
// - high routine never pre-empted; low only by high
//
// The Avalon-MM register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "stlc_defs.svh"
module stlc_irq_ctrl (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire stlc_pkg::stlc_src_t src_req,
  output logic irq_req,
  output logic [15:0] irq_vector,
  input wire logic irq_ack,
  input wire logic irq_return
);
  import stlc_pkg::*;

  logic [7:0] enable_ff;
  logic [7:0] level_ff;
  logic [1:0] active_ff;
  logic irq_req_ff;
  logic [15:0] irq_vector_ff;
  logic [2:0] sel_ff;
  logic sel_high_ff;
  logic [31:0] readdata_ff;
  logic wait_ff;
  stlc_state_t state_ff;

  // source bit order matches enable and level bit order
  stlc_src_t gated;
  stlc_src_t hi_req;
  stlc_src_t lo_req;
  logic [2:0] nxt_sel;
  logic nxt_high;
  logic nxt_valid;
  logic [15:0] nxt_vector;
  logic may_hi;
  logic may_lo;

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_src
      // gate 1 passes, 0 blocks; global bit over all
      assign gated[gi] = src_req[gi] & enable_ff[gi] & enable_ff[`STLC_BIT_GLOBAL];
      assign hi_req[gi] = gated[gi] & level_ff[gi];
      assign lo_req[gi] = gated[gi] & ~level_ff[gi];
    end
  endgenerate

  // high accepted unless a high routine runs; low only when nothing runs
  assign may_hi = ~active_ff[1];
  assign may_lo = (active_ff == 2'b00);

  function automatic logic [2:0] stlc_pick(input stlc_src_t r);
    logic [2:0] s;
    s = 3'(STLC_SRC_EXT_A);
    if (r[0]) begin
      s = 3'(STLC_SRC_EXT_A);
    end else if (r[5]) begin
      s = 3'(STLC_SRC_TWOWIRE);
    end else if (r[1]) begin
      s = 3'(STLC_SRC_TIMER_A);
    end else if (r[2]) begin
      s = 3'(STLC_SRC_EXT_B);
    end else if (r[3]) begin
      s = 3'(STLC_SRC_TIMER_B);
    end else if (r[4]) begin
      s = 3'(STLC_SRC_ASYNC);
    end
    return s;
  endfunction : stlc_pick

  always_comb begin
    nxt_sel = 3'h0;
    nxt_high = 1'b0;
    nxt_valid = 1'b0;
    if (may_hi && (hi_req != 6'h00)) begin
      nxt_sel = stlc_pick(hi_req);
      nxt_high = 1'b1;
      nxt_valid = 1'b1;
    end else if (may_lo && (lo_req != 6'h00)) begin
      nxt_sel = stlc_pick(lo_req);
      nxt_valid = 1'b1;
    end
  end

  always_comb begin
    case (nxt_sel)
      3'(STLC_SRC_EXT_A): nxt_vector = `STLC_VEC_EXT_A;
      3'(STLC_SRC_TIMER_A): nxt_vector = `STLC_VEC_TIMER_A;
      3'(STLC_SRC_EXT_B): nxt_vector = `STLC_VEC_EXT_B;
      3'(STLC_SRC_TIMER_B): nxt_vector = `STLC_VEC_TIMER_B;
      3'(STLC_SRC_ASYNC): nxt_vector = `STLC_VEC_ASYNC;
      3'(STLC_SRC_TWOWIRE): nxt_vector = `STLC_VEC_TWOWIRE;
      default: nxt_vector = `STLC_VEC_EXT_A;
    endcase
  end

  // offer stays frozen until ack so the core never sees the vector change mid-handshake
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff <= STLC_IDLE;
      irq_req_ff <= 1'b0;
      irq_vector_ff <= 16'h0000;
      sel_ff <= 3'h0;
      sel_high_ff <= 1'b0;
    end else begin
      case (state_ff)
        STLC_IDLE: begin
          if (nxt_valid) begin
            state_ff <= STLC_OFFER;
            irq_req_ff <= 1'b1;
            irq_vector_ff <= nxt_vector;
            sel_ff <= nxt_sel;
            sel_high_ff <= nxt_high;
          end
        end
        STLC_OFFER: begin
          if (irq_ack) begin
            state_ff <= STLC_IDLE;
            irq_req_ff <= 1'b0;
          end
        end
        default: begin
          state_ff <= STLC_IDLE;
          irq_req_ff <= 1'b0;
        end
      endcase
    end
  end

  // in-service levels; ack pushes, return pops the highest
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      active_ff <= 2'b00;
    end else if (state_ff == STLC_OFFER && irq_ack) begin
      if (sel_high_ff) begin
        active_ff[1] <= 1'b1;
      end else begin
        active_ff[0] <= 1'b1;
      end
    end else if (irq_return) begin
      if (active_ff[1]) begin
        active_ff[1] <= 1'b0;
      end else begin
        active_ff[0] <= 1'b0;
      end
    end
  end

  // registers: one wait cycle per access so readdata is registered
  logic bus_go;
  assign bus_go = (avs_read | avs_write) & wait_ff;
  // a write lands only on the edge where the master sees waitrequest low
  logic bus_done;
  assign bus_done = avs_write & ~wait_ff;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= ~bus_go;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      enable_ff <= `STLC_RST_ENABLE;
      level_ff <= `STLC_RST_LEVEL;
    end else if (bus_done && avs_byteenable[0]) begin
      if (avs_address == `STLC_OFF_ENABLE) begin
        // bit 6 unused, held at zero
        enable_ff <= avs_writedata[7:0] & `STLC_ENABLE_MASK;
      end else if (avs_address == `STLC_OFF_LEVEL) begin
        level_ff <= avs_writedata[7:0] & `STLC_LEVEL_MASK;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      readdata_ff <= 32'h0000_0000;
    end else if (bus_go && avs_read) begin
      case (avs_address)
        `STLC_OFF_ENABLE: readdata_ff <= {24'h000000, enable_ff};
        `STLC_OFF_LEVEL: readdata_ff <= {24'h000000, level_ff};
        `STLC_OFF_STATUS: readdata_ff <= {10'h000, src_req, 5'h00, sel_ff,
                                          3'h0, irq_req_ff, 2'b00, active_ff};
        default: readdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign avs_readdata = readdata_ff;
  assign avs_waitrequest = wait_ff;
  assign irq_req = irq_req_ff;
  assign irq_vector = irq_vector_ff;

  property p_global_block;
    @(posedge clk_sys) disable iff (rst)
      (state_ff == STLC_IDLE && !enable_ff[`STLC_BIT_GLOBAL]) |=> !irq_req_ff;
  endproperty
  a_global_block: assert property (p_global_block) else $error("request with global off");

  // sel_ff is new at the rising edge, so only the request and enable words are taken from the past
  property p_gate;
    @(posedge clk_sys) disable iff (rst)
      $rose(irq_req_ff) |-> $past(enable_ff[`STLC_BIT_GLOBAL]) &&
        ((($past(src_req) & $past(enable_ff[5:0])) >> sel_ff) & 6'h01) != 6'h00;
  endproperty
  a_gate: assert property (p_gate) else $error("offer from gated source");

  property p_vector;
    @(posedge clk_sys) disable iff (rst)
      irq_req_ff |-> irq_vector_ff == `STLC_VEC_EXT_A + {10'h000, sel_ff, 3'h0};
  endproperty
  a_vector: assert property (p_vector) else $error("vector mismatch");

  property p_level;
    @(posedge clk_sys) disable iff (rst)
      $rose(irq_req_ff) |->
        sel_high_ff == ((($past(level_ff[5:0]) >> sel_ff) & 6'h01) != 6'h00);
  endproperty
  a_level: assert property (p_level) else $error("level mismatch");

  property p_no_preempt_high;
    @(posedge clk_sys) disable iff (rst)
      active_ff[1] |-> ##1 !$rose(irq_req_ff);
  endproperty
  a_no_preempt_high: assert property (p_no_preempt_high) else $error("high pre-empted");

  property p_low_only_high;
    @(posedge clk_sys) disable iff (rst)
      (active_ff == 2'b01 && state_ff == STLC_IDLE) |=> (!irq_req_ff || sel_high_ff);
  endproperty
  a_low_only_high: assert property (p_low_only_high) else $error("low pre-empts low");

  property p_hold;
    @(posedge clk_sys) disable iff (rst)
      (irq_req_ff && !irq_ack) |=> irq_req_ff && $stable(irq_vector_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("offer dropped before ack");

  property p_ack_level;
    @(posedge clk_sys) disable iff (rst)
      (irq_req_ff && irq_ack && sel_high_ff) |=> active_ff[1];
  endproperty
  a_ack_level: assert property (p_ack_level) else $error("level not recorded");

  // a free path with nothing in service must turn into an offer
  property p_pass_enabled;
    @(posedge clk_sys) disable iff (rst)
      (state_ff == STLC_IDLE && active_ff == 2'b00 && enable_ff[`STLC_BIT_GLOBAL] &&
        (src_req & enable_ff[5:0]) != 6'h00) |=> irq_req_ff;
  endproperty
  a_pass_enabled: assert property (p_pass_enabled) else $error("request ignored");

  property p_unused_gate;
    @(posedge clk_sys) disable iff (rst)
      !enable_ff[`STLC_BIT_UNUSED];
  endproperty
  a_unused_gate: assert property (p_unused_gate) else $error("unused gate bit set");

  property p_unused_level;
    @(posedge clk_sys) disable iff (rst)
      level_ff[7:6] == 2'b00;
  endproperty
  a_unused_level: assert property (p_unused_level) else $error("unused level bits set");

  // table check per source, independent of the index arithmetic above
  property p_vec_ext_a;
    @(posedge clk_sys) disable iff (rst)
      (irq_req_ff && sel_ff == 3'(STLC_SRC_EXT_A)) |-> irq_vector_ff == `STLC_VEC_EXT_A;
  endproperty
  a_vec_ext_a: assert property (p_vec_ext_a) else $error("external a vector");

  property p_vec_timer_a;
    @(posedge clk_sys) disable iff (rst)
      (irq_req_ff && sel_ff == 3'(STLC_SRC_TIMER_A)) |-> irq_vector_ff == `STLC_VEC_TIMER_A;
  endproperty
  a_vec_timer_a: assert property (p_vec_timer_a) else $error("timer a vector");

  property p_vec_ext_b;
    @(posedge clk_sys) disable iff (rst)
      (irq_req_ff && sel_ff == 3'(STLC_SRC_EXT_B)) |-> irq_vector_ff == `STLC_VEC_EXT_B;
  endproperty
  a_vec_ext_b: assert property (p_vec_ext_b) else $error("external b vector");

  property p_vec_timer_b;
    @(posedge clk_sys) disable iff (rst)
      (irq_req_ff && sel_ff == 3'(STLC_SRC_TIMER_B)) |-> irq_vector_ff == `STLC_VEC_TIMER_B;
  endproperty
  a_vec_timer_b: assert property (p_vec_timer_b) else $error("timer b vector");

  property p_vec_async;
    @(posedge clk_sys) disable iff (rst)
      (irq_req_ff && sel_ff == 3'(STLC_SRC_ASYNC)) |-> irq_vector_ff == `STLC_VEC_ASYNC;
  endproperty
  a_vec_async: assert property (p_vec_async) else $error("async vector");

  property p_vec_twowire;
    @(posedge clk_sys) disable iff (rst)
      (irq_req_ff && sel_ff == 3'(STLC_SRC_TWOWIRE)) |-> irq_vector_ff == `STLC_VEC_TWOWIRE;
  endproperty
  a_vec_twowire: assert property (p_vec_twowire) else $error("two-wire vector");

  // head of the equal-level order among low requests
  property p_order_ext_a;
    @(posedge clk_sys) disable iff (rst)
      (state_ff == STLC_IDLE && nxt_valid && hi_req == 6'h00 && lo_req[0]) |=>
        sel_ff == 3'(STLC_SRC_EXT_A);
  endproperty
  a_order_ext_a: assert property (p_order_ext_a) else $error("external a not first");

  property p_order_twowire;
    @(posedge clk_sys) disable iff (rst)
      (state_ff == STLC_IDLE && nxt_valid && hi_req == 6'h00 && lo_req[5] && !lo_req[0]) |=>
        sel_ff == 3'(STLC_SRC_TWOWIRE);
  endproperty
  a_order_twowire: assert property (p_order_twowire) else $error("two-wire not second");

  property p_order_timer_a;
    @(posedge clk_sys) disable iff (rst)
      (state_ff == STLC_IDLE && nxt_valid && hi_req == 6'h00 && lo_req[1] &&
        !lo_req[0] && !lo_req[5]) |=> sel_ff == 3'(STLC_SRC_TIMER_A);
  endproperty
  a_order_timer_a: assert property (p_order_timer_a) else $error("timer a not third");

  property p_high_first;
    @(posedge clk_sys) disable iff (rst)
      (state_ff == STLC_IDLE && nxt_valid && hi_req != 6'h00) |=> sel_high_ff;
  endproperty
  a_high_first: assert property (p_high_first) else $error("low picked over high");

  property p_low_wait;
    @(posedge clk_sys) disable iff (rst)
      (state_ff == STLC_IDLE && active_ff == 2'b01 && hi_req == 6'h00) |=> !irq_req_ff;
  endproperty
  a_low_wait: assert property (p_low_wait) else $error("low routine pre-empted by low");

  // ack wins over a return in the same cycle, so that case is left out
  property p_return_pop;
    @(posedge clk_sys) disable iff (rst)
      (irq_return && !(irq_req_ff && irq_ack) && active_ff[1]) |=>
        !active_ff[1] && active_ff[0] == $past(active_ff[0]);
  endproperty
  a_return_pop: assert property (p_return_pop) else $error("return did not pop high");

  property p_ack_low;
    @(posedge clk_sys) disable iff (rst)
      (irq_req_ff && irq_ack && !sel_high_ff) |=> active_ff[0];
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("low level not recorded");

  property p_offer_drop;
    @(posedge clk_sys) disable iff (rst)
      (irq_req_ff && irq_ack) |=> !irq_req_ff;
  endproperty
  a_offer_drop: assert property (p_offer_drop) else $error("offer kept after ack");
endmodule : stlc_irq_ctrl

/* design/stlc_pkg.sv */
// types shared by the interrupt controller
package stlc_pkg;
  typedef logic [5:0] stlc_src_t;
  typedef enum logic [2:0] {
    STLC_SRC_EXT_A,
    STLC_SRC_TIMER_A,
    STLC_SRC_EXT_B,
    STLC_SRC_TIMER_B,
    STLC_SRC_ASYNC,
    STLC_SRC_TWOWIRE
  } stlc_sel_t;
  typedef enum {STLC_IDLE, STLC_OFFER} stlc_state_t;
endpackage : stlc_pkg

/* tb/stlc_core_model.sv */
// core sequencer model: takes offered vectors, signals routine return
`timescale 1ns/1ps
module stlc_core_model (
  input logic clk_sys,
  input logic rst,
  input logic irq_req,
  input logic [15:0] irq_vector,
  input logic [3:0] ack_delay,
  input logic ret_go,
  output logic irq_ack,
  output logic irq_return,
  output logic [15:0] last_vec,
  output int n_ack
);
  logic [3:0] stall_ff;
  // stall lets the bench play a slow core as well as a prompt one
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stall_ff <= 4'h0;
      irq_ack <= 1'b0;
      last_vec <= 16'h0000;
      n_ack <= 0;
    end else if (irq_req && !irq_ack && stall_ff == ack_delay) begin
      irq_ack <= 1'b1;
      last_vec <= irq_vector;
      n_ack <= n_ack + 1;
      stall_ff <= 4'h0;
    end else begin
      irq_ack <= 1'b0;
      stall_ff <= (irq_req && !irq_ack) ? stall_ff + 4'h1 : 4'h0;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) irq_return <= 1'b0;
    else irq_return <= ret_go;
  end
endmodule : stlc_core_model

/* tb/stlc_irq_ctrl_bench.sv */
// bench for the interrupt controller: register port and vector hand-off
`timescale 1ns/1ps
module stlc_irq_ctrl_bench;
  logic clk_sys = 0, rst = 1, avs_read = 0, avs_write = 0, avs_waitrequest;
  logic irq_req, irq_ack, irq_return, ret_go = 0;
  logic [3:0] avs_address = 4'h0, ack_delay = 4'h0, avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [15:0] irq_vector, last_vec;
  stlc_pkg::stlc_src_t src_req = 6'h00;
  int n_ack, n_errors = 0, checks_done = 0, cyc = 0, k;
  int order[6] = '{0, 5, 1, 2, 3, 4};
  logic [5:0] m;
  always #10 clk_sys = ~clk_sys;
  stlc_irq_ctrl i_dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .src_req(src_req), .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack),
    .irq_return(irq_return));
  stlc_core_model i_core (.clk_sys(clk_sys), .rst(rst), .irq_req(irq_req),
    .irq_vector(irq_vector), .ack_delay(ack_delay), .ret_go(ret_go), .irq_ack(irq_ack),
    .irq_return(irq_return), .last_vec(last_vec), .n_ack(n_ack));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    // request stands until waitrequest is seen low at a rising edge; answer taken there
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task serve(input logic [5:0] s, input logic [15:0] v, input string nm);
    int t;
    k = n_ack;
    src_req <= s;
    t = 0;
    while (n_ack == k && t < 40) begin
      @(posedge clk_sys);
      t++;
    end
    chk({nm, " ack"}, k + 1, n_ack);
    chk(nm, {16'h0, v}, {16'h0, last_vec});
  endtask : serve
  task quiet(input string nm);
    k = n_ack;
    repeat (4) @(posedge clk_sys);
    chk(nm, k, n_ack);
  endtask : quiet
  task ret;
    src_req <= 6'h00;
    @(posedge clk_sys);
    ret_go <= 1'b1;
    @(posedge clk_sys);
    ret_go <= 1'b0;
    @(posedge clk_sys);
  endtask : ret
  task results;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 5000) begin
      n_errors++;
      results();
    end
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    bus(0, 4'h0, 8'h00); chk("enable reset", 32'h0, q);
    bus(1, 4'h0, 8'hff);
    bus(0, 4'h0, 8'h00); chk("enable bit6", 32'hbf, q);
    bus(1, 4'h4, 8'hff);
    bus(0, 4'h4, 8'h00); chk("level bits 7:6", 32'h3f, q);
    avs_byteenable <= 4'he;
    bus(1, 4'h4, 8'h00);
    avs_byteenable <= 4'hf;
    bus(0, 4'h4, 8'h00); chk("lane 0 off", 32'h3f, q);
    bus(0, 4'hc, 8'h00); chk("unmapped", 32'h0, q);
    $display("test registers done");
    bus(1, 4'h4, 8'h00);
    // one gate open at a time with every source requesting
    for (int i = 0; i < 6; i++) begin
      ack_delay <= 4'(i % 2 * 3);
      bus(1, 4'h0, 8'h80 | 8'(1 << i));
      serve(6'h3f, 16'h0003 + 16'(i * 8), "gated vector");
      ret();
    end
    bus(1, 4'h0, 8'h3f);
    src_req <= 6'h3f;
    quiet("global off");
    src_req <= 6'h00;
    $display("test gates done");
    bus(1, 4'h0, 8'hbf);
    m = 6'h3f;
    for (int i = 0; i < 6; i++) begin
      serve(m, 16'h0003 + 16'(order[i] * 8), "equal order");
      m[order[i]] = 1'b0;
      ret();
    end
    bus(1, 4'h4, 8'h10);
    serve(6'h3f, 16'h0023, "high wins");
    ret();
    $display("test priority done");
    bus(1, 4'h4, 8'h04);
    serve(6'h02, 16'h000b, "low routine");
    src_req <= 6'h01;
    quiet("low on low");
    serve(6'h05, 16'h0013, "nested high");
    bus(0, 4'h8, 8'h00); chk("status nested", 32'h0005_0203, q);
    bus(1, 4'h4, 8'h05);
    quiet("high on high");
    ret();
    ret();
    $display("test nesting done");
    results();
  end
endmodule : stlc_irq_ctrl_bench
